// [bench/acq_dev_model.sv]
// device model: busy timing of the sampling converter
// assumes start pins and busy are synchronous to the host clock
`timescale 1ns/1ns
`default_nettype none
module acq_dev_model (
  // host pins
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       dev_reset,
  input  wire logic       start_a,
  input  wire logic       start_b,
  input  wire logic [2:0] os_sel,
  // status
  output var  logic       busy
);
  // worst conversion time per ratio, in cycles
  localparam int LIM [7] = '{525, 1137, 2350, 4875, 9750, 19750, 39375};
  int   cnt;                         // cycles left
  logic a_q, b_q, a_seen, b_seen;    // edge memory
  wire  a_up = a_seen | (start_a & !a_q);
  wire  b_up = b_seen | (start_b & !b_q);
  // conversion starts once both inputs rose, ends at 3/4 of limit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {busy, a_q, b_q, a_seen, b_seen} <= '0;
      cnt <= 0;
    end else begin
      a_q <= start_a;
      b_q <= start_b;
      if (dev_reset) begin
        {busy, a_seen, b_seen} <= '0;
      end else if (busy) begin
        if (cnt == 0) busy <= 1'b0;
        cnt <= cnt - 1;
      end else begin
        a_seen <= a_up & !b_up;
        b_seen <= b_up & !a_up;
        if (a_up && b_up) begin
          busy <= 1'b1;
          cnt  <= LIM[os_sel] * 3 / 4;
        end
      end
    end
  end
endmodule : acq_dev_model
`default_nettype wire

// [bench/acq_host_assertions.sv]
// checker: timing of the controller's device pins
// assumes it is bound to the host controller top module
`timescale 1ns/1ns
`default_nettype none
module acq_host_assertions #(parameter int unsigned LOW_POWER_REQUEST_CYC = 20) (
  // clock, reset, bus
  input wire logic       I_CLOCK,
  input wire logic       I_RST_B,
  input wire logic       I_WB_CYC,
  input wire logic       I_WB_STB,
  input wire logic       O_WB_ACK,
  // device pins
  input wire logic       I_BUSY,
  input wire logic       O_SAMPLE_START_A,
  input wire logic       O_SAMPLE_START_B,
  input wire logic       O_DEV_RESET,
  input wire logic       O_LOW_POWER_REQUEST_B,
  input wire logic [2:0] O_OVERSAMPLE_SELECT,
  input wire logic       O_READ_OK
);
  localparam int unsigned SKEW_MAX = acq_pkg::C_AB_SKEW;
  int unsigned wake_cnt; // cycles since low power released
  int unsigned skew_cnt; // cycles a leads b
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_B);
  // helper counters
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) wake_cnt <= 32'hffff_ffff;
    else if (!O_LOW_POWER_REQUEST_B) wake_cnt <= 32'h0000_0000;
    else if (wake_cnt != 32'hffff_ffff) wake_cnt <= wake_cnt + 1;
  end
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) skew_cnt <= 0;
    else if (O_SAMPLE_START_A && !O_SAMPLE_START_B) skew_cnt <= skew_cnt + 1;
    else skew_cnt <= 0;
  end
  property p_rst_w; $rose(O_DEV_RESET) |-> O_DEV_RESET [*7]; endproperty
  a_rst_w: assert property (p_rst_w) else $error("reset pulse short");
  property p_rst_gap; $fell(O_DEV_RESET) |-> !(O_SAMPLE_START_A || O_SAMPLE_START_B) [*4]; endproperty
  a_rst_gap: assert property (p_rst_gap) else $error("start too soon after reset");
  property p_wake; $rose(O_SAMPLE_START_A) |-> wake_cnt >= LOW_POWER_REQUEST_CYC; endproperty
  a_wake: assert property (p_wake) else $error("start too soon after wake");
  property p_lp; !O_LOW_POWER_REQUEST_B |-> !(O_SAMPLE_START_A || O_SAMPLE_START_B); endproperty
  a_lp: assert property (p_lp) else $error("start in low power");
  property p_skew; skew_cnt <= SKEW_MAX; endproperty
  a_skew: assert property (p_skew) else $error("second start late");
  property p_fall; $fell(O_SAMPLE_START_A) |-> $fell(O_SAMPLE_START_B); endproperty
  a_fall: assert property (p_fall) else $error("starts fell apart");
  property p_ok_busy; O_READ_OK |-> !$past(I_BUSY); endproperty
  a_ok_busy: assert property (p_ok_busy) else $error("read allowed while busy");
  property p_ok_fall; $fell(I_BUSY) |=> O_READ_OK; endproperty
  a_ok_fall: assert property (p_ok_fall) else $error("read not allowed");
  property p_ok_start; (O_SAMPLE_START_A || O_SAMPLE_START_B) |-> !O_READ_OK; endproperty
  a_ok_start: assert property (p_ok_start) else $error("read allowed at start");
  property p_os; I_BUSY |-> $stable(O_OVERSAMPLE_SELECT); endproperty
  a_os: assert property (p_os) else $error("ratio moved in conversion");
  property p_ack; I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK ##1 !O_WB_ACK; endproperty
  a_ack: assert property (p_ack) else $error("bus ack wrong");
endmodule : acq_host_assertions
`default_nettype wire

// [bench/acq_host_bench.sv]
// bench: host controller against a device model over wishbone
// assumes a shortened wake wait set by parameters
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module acq_host_bench;
  logic clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, busy, ack, sa, sb, drst, lpb, rok;
  logic [3:0] adr = 0, sel = 0;
  logic [31:0] dat = 0, rd, q;
  logic [2:0] os;
  int err_total = 0, n_tests = 0, seed, cn = 0, t_a, t_b, t_lp, t_rf, rw, sk, ser, c;
  logic pa = 0, pb = 0, pr = 0, pl = 1;
  int lim_w [3] = '{20, 30, 40};
  always #4 clk = ~clk;
  acq_host #(.SHDN_INT_CYC(40), .SHDN_EXT_CYC(30), .LOW_POWER_REQUEST_CYC(20)) dut_u (
    .I_CLOCK(clk), .I_RST_B(rst_b), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(dat), .O_WB_DAT(rd), .O_WB_ACK(ack),
    .I_BUSY(busy), .O_SAMPLE_START_A(sa), .O_SAMPLE_START_B(sb), .O_DEV_RESET(drst),
    .O_LOW_POWER_REQUEST_B(lpb), .O_OVERSAMPLE_SELECT(os), .O_READ_OK(rok));
  acq_dev_model dev_u (.clk(clk), .rst_b(rst_b), .dev_reset(drst), .start_a(sa),
    .start_b(sb), .os_sel(os), .busy(busy));
  // pin event times in cycles
  always @(posedge clk) begin
    cn++;
    if (sa && !pa) t_a = cn;
    if (sb && !pb) t_b = cn;
    if (lpb && !pl) t_lp = cn;
    if (!drst && pr) t_rf = cn;
    rw = drst ? (pr ? rw + 1 : 1) : rw;
    {pa, pb, pr, pl} = {sa, sb, drst, lpb};
  end
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, dat, sel} <= {1'b1, 1'b1, w, a, d, 4'hf};
    do @(posedge clk); while (ack !== 1'b1);
    q = rd;
    {cyc, stb} <= 2'b00;
  endtask : wb
  task automatic wait_ok;
    int n;
    n = 0;
    while (sa !== 1'b1 && n < 50000) begin @(posedge clk); n++; end
    while (rok !== 1'b1 && n < 50000) begin @(posedge clk); n++; end
    `CHK(n < 50000, 1'b1)
  endtask : wait_ok
  task automatic give_verdict;
    $display("mismatches %0d of %0d checks", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  initial begin
    #(8 * 99000);
    err_total++;
    give_verdict;
  end
  initial begin
    seed = 32'ha596;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    wb(0, 4'hc, 0); `CHK(q, 32'h0000_0000)
    wb(0, acq_pkg::ADR_CTRL, 0); `CHK(q, acq_pkg::CTRL_RST)
    for (int m = 0; m < 3; m++) begin
      c = (1 << acq_pkg::F_LOWP) | ((m > 0) << acq_pkg::F_SHDN) | ((m == 1) << acq_pkg::F_EXTREF);
      wb(1, acq_pkg::ADR_CTRL, c);
      repeat (4) @(posedge clk);
      `CHK(lpb, 1'b0)
      wb(1, acq_pkg::ADR_CTRL, (c ^ (1 << acq_pkg::F_LOWP)) | 1);
      wait_ok;
      `CHK(t_a - t_lp >= lim_w[m], 1'b1)
    end
    for (int o = 0; o < 7; o++) begin
      sk = $random(seed) & 15;
      ser = $random(seed) & 1;
      wb(1, acq_pkg::ADR_SKEW, sk);
      wb(0, acq_pkg::ADR_SKEW, 0); `CHK(q, sk)
      wb(1, acq_pkg::ADR_CTRL, (o << 8) | (ser << 5) | 3);
      wait_ok;
      `CHK(t_b - t_a, sk)
      `CHK(rw >= 7, 1'b1)
      `CHK(t_a - t_rf >= 4, 1'b1)
      `CHK(os, o[2:0])
      `CHK(busy, 1'b0)
      repeat (8) @(posedge clk);
      wb(0, acq_pkg::ADR_STATUS, 0);
      c = dev_u.LIM[o] * 3 / 4 > (ser ? acq_pkg::C_CYC_SER : acq_pkg::C_CYC_PAR);
      `CHK(q[4:0], {c[0], 4'b0101})
    end
    give_verdict;
  end
endmodule : acq_host_bench
bind acq_host acq_host_assertions #(.LOW_POWER_REQUEST_CYC(LOW_POWER_REQUEST_CYC)) chk_u (.I_CLOCK, .I_RST_B,
  .I_WB_CYC, .I_WB_STB, .O_WB_ACK, .I_BUSY, .O_SAMPLE_START_A, .O_SAMPLE_START_B,
  .O_DEV_RESET, .O_LOW_POWER_REQUEST_B, .O_OVERSAMPLE_SELECT, .O_READ_OK);
`default_nettype wire

// [design/acq_host.sv]
// host controller: sequences resets, wake-up, start pulses and busy for
// the sampling converter; software reaches it over classic wishbone
// assumes device pins synchronous to I_CLOCK; reads of results are done
// by a separate read engine that waits for O_READ_OK
// Contract
// - parallel conversion-and-read cycle within 5 us
// - serial read-after cycle up to 9.1 us
// - wait 100 us after standby release
// - wait 30 or 13 ms after shutdown
// - hold reset high at least 50 ns
// - 25 ns from reset low to start
// - second start within 0.5 ms of first
// - select only after busy has fallen
// - last select release within 25 ns busy-fall
//
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module acq_host #(
  parameter int unsigned SHDN_INT_CYC = acq_pkg::C_SHDN_INT,
  parameter int unsigned SHDN_EXT_CYC = acq_pkg::C_SHDN_EXT,
  parameter int unsigned LOW_POWER_REQUEST_CYC     = acq_pkg::C_LOW_POWER_REQUEST
) (
  // clock and reset
  input  wire logic        I_CLOCK,
  input  wire logic        I_RST_B,
  // wishbone slave
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [3:0]  I_WB_ADR,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic [31:0] I_WB_DAT,
  output var  logic [31:0] O_WB_DAT,
  output var  logic        O_WB_ACK,
  // device pins
  input  wire logic        I_BUSY,
  output var  logic        O_SAMPLE_START_A,
  output var  logic        O_SAMPLE_START_B,
  output var  logic        O_DEV_RESET,
  output var  logic        O_LOW_POWER_REQUEST_B,
  output var  logic [2:0]  O_OVERSAMPLE_SELECT,
  // read engine handshake
  output var  logic        O_READ_OK
);
  localparam int unsigned CW = 32;
  // elaboration check: every wake wait needs at least one cycle
  if (SHDN_INT_CYC < 1 || SHDN_EXT_CYC < 1 || LOW_POWER_REQUEST_CYC < 1) begin : g_bad_wake
    $error("wake counts must be at least one");
  end

  acq_pkg::acq_state_e state_reg;              // sequencer state
  logic [CW-1:0]       cnt_reg;                // state timer
  logic [CW-1:0]       cyc_reg;                // throughput cycle timer
  logic [31:0]         ctrl_reg;               // control register
  logic [15:0]         skew_reg;               // a-to-b start skew, cycles
  logic                done_reg;               // sticky conversion done
  logic                late_reg;               // sticky busy overlong
  logic                over_reg;               // sticky cycle overrun
  logic                start_req_reg;          // pending start command
  logic                reset_req_reg;          // pending reset command
  logic                lowp_prev_reg;          // last low power level
  logic                wake_req_reg;           // wake wait pending
  logic                busy_prev_reg;          // busy one cycle ago
  logic [CW-1:0]       wake_len;               // wake wait length
  logic [CW-1:0]       conv_lim;               // busy limit for ratio
  logic                wr_ctrl;                // control write strobe
  logic                busy_fall;              // busy falling edge
  logic                lowp_fall;              // low power just released
  logic                start_go;               // start taken this cycle
  logic [CW-1:0]       skew_eff;               // skew held to its cap

  assign wr_ctrl   = I_WB_CYC && I_WB_STB && I_WB_WE && !O_WB_ACK && I_WB_ADR == acq_pkg::ADR_CTRL;
  assign busy_fall = busy_prev_reg && !I_BUSY;
  assign lowp_fall = lowp_prev_reg && !ctrl_reg[acq_pkg::F_LOWP];
  // a start never slips past a release that has not yet become a wake wait
  assign start_go  = state_reg == acq_pkg::ST_IDLE && !reset_req_reg && !wake_req_reg && !lowp_fall &&
                     start_req_reg && !ctrl_reg[acq_pkg::F_LOWP] && !I_BUSY;
  // skew as actually applied, never beyond the 0.5 ms cap
  assign skew_eff  = (CW'(skew_reg) > CW'(acq_pkg::C_AB_SKEW)) ? CW'(acq_pkg::C_AB_SKEW) : CW'(skew_reg);
  // standby wait unless shutdown is set, then shutdown wait by reference choice
  assign wake_len  = !ctrl_reg[acq_pkg::F_SHDN] ? CW'(LOW_POWER_REQUEST_CYC) :
                     ctrl_reg[acq_pkg::F_EXTREF] ? CW'(SHDN_EXT_CYC) : CW'(SHDN_INT_CYC);
  // busy limit doubles exactly with each ratio; twice the 4.2 us base at ratio 0
  assign conv_lim  = CW'(acq_pkg::C_CONV_OFF) * (CW'(1) << ctrl_reg[acq_pkg::F_OS +: 3]) * CW'(2);

  // wishbone ack and read data, one cycle answer
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h0000_0000;
    end else begin
      O_WB_ACK <= I_WB_CYC && I_WB_STB && !O_WB_ACK;
      if (I_WB_CYC && I_WB_STB && !O_WB_ACK && !I_WB_WE) begin
        unique case (I_WB_ADR)
          acq_pkg::ADR_CTRL:   O_WB_DAT <= ctrl_reg;
          acq_pkg::ADR_STATUS: O_WB_DAT <= {27'h000_0000, over_reg, late_reg, done_reg, I_BUSY,
                                            state_reg == acq_pkg::ST_IDLE};
          acq_pkg::ADR_SKEW:   O_WB_DAT <= {16'h0000, skew_reg};
          default:             O_WB_DAT <= 32'h0000_0000;
        endcase
      end
    end
  end

  // control and skew registers, with byte enables
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ctrl_reg <= acq_pkg::CTRL_RST;
      skew_reg <= 16'h0000;
    end else if (I_WB_CYC && I_WB_STB && I_WB_WE && !O_WB_ACK) begin
      for (int i = 0; i < 4; i++) begin
        if (I_WB_SEL[i] && I_WB_ADR == acq_pkg::ADR_CTRL) ctrl_reg[i*8 +: 8] <= I_WB_DAT[i*8 +: 8];
      end
      if (I_WB_ADR == acq_pkg::ADR_SKEW && I_WB_SEL[0]) skew_reg[7:0] <= I_WB_DAT[7:0];
      if (I_WB_ADR == acq_pkg::ADR_SKEW && I_WB_SEL[1]) skew_reg[15:8] <= I_WB_DAT[15:8];
    end else begin
      ctrl_reg[acq_pkg::F_START] <= 1'b0;  // self clearing
      ctrl_reg[acq_pkg::F_RESET] <= 1'b0;
    end
  end

  // pending commands; set on write, cleared when taken
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      start_req_reg <= 1'b0;
      reset_req_reg <= 1'b0;
      wake_req_reg  <= 1'b0;
      lowp_prev_reg <= 1'b0;
    end else begin
      lowp_prev_reg <= ctrl_reg[acq_pkg::F_LOWP];
      if (wr_ctrl && I_WB_SEL[0] && I_WB_DAT[acq_pkg::F_START]) start_req_reg <= 1'b1;
      else if (state_reg == acq_pkg::ST_START) start_req_reg <= 1'b0;
      if (wr_ctrl && I_WB_SEL[0] && I_WB_DAT[acq_pkg::F_RESET]) reset_req_reg <= 1'b1;
      else if (state_reg == acq_pkg::ST_RESET) reset_req_reg <= 1'b0;
      if (lowp_fall) wake_req_reg <= 1'b1;
      else if (state_reg == acq_pkg::ST_WAKE) wake_req_reg <= 1'b0;
    end
  end

  // sequencer: reset pulse, wake wait, start pulses, busy tracking
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state_reg        <= acq_pkg::ST_IDLE;
      cnt_reg          <= '0;
      O_SAMPLE_START_A <= 1'b0;
      O_SAMPLE_START_B <= 1'b0;
      O_DEV_RESET      <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + CW'(1);
      unique case (state_reg)
        acq_pkg::ST_IDLE: begin
          cnt_reg <= '0;
          if (reset_req_reg) begin
            state_reg   <= acq_pkg::ST_RESET;
            O_DEV_RESET <= 1'b1;
          end else if (wake_req_reg || lowp_fall) begin
            state_reg <= acq_pkg::ST_WAKE;
          end else if (start_go) begin
            state_reg        <= acq_pkg::ST_START;
            O_SAMPLE_START_A <= 1'b1;
            O_SAMPLE_START_B <= (skew_reg == 16'h0000);
          end
        end
        acq_pkg::ST_RESET: begin
          if (cnt_reg == CW'(acq_pkg::C_RESET - 1)) O_DEV_RESET <= 1'b0;
          if (cnt_reg == CW'(acq_pkg::C_RESET + acq_pkg::C_RST_CONV - 1)) begin
            state_reg <= acq_pkg::ST_IDLE;
          end
        end
        acq_pkg::ST_WAKE: begin
          if (cnt_reg >= wake_len - CW'(1)) state_reg <= acq_pkg::ST_IDLE;
        end
        acq_pkg::ST_START: begin
          // b follows a within the skew setting, capped at 0.5 ms
          if (cnt_reg + CW'(1) >= CW'(skew_reg) || cnt_reg >= CW'(acq_pkg::C_AB_SKEW - 1))
            O_SAMPLE_START_B <= 1'b1;
          // b, too, stays high at least 25 ns after it rose
          if (cnt_reg >= skew_eff + CW'(acq_pkg::C_START_HI - 1) && O_SAMPLE_START_B) begin
            O_SAMPLE_START_A <= 1'b0;
            O_SAMPLE_START_B <= 1'b0;
            state_reg        <= acq_pkg::ST_WAIT;
            cnt_reg          <= '0;
          end
        end
        acq_pkg::ST_WAIT: begin
          // busy rises within 40 ns of start
          if (I_BUSY) state_reg <= acq_pkg::ST_CONV;
          else if (cnt_reg == CW'(acq_pkg::C_START_HI)) state_reg <= acq_pkg::ST_CONV;
        end
        acq_pkg::ST_CONV: begin
          if (!I_BUSY) begin
            state_reg <= acq_pkg::ST_HOLD;
            cnt_reg   <= '0;
          end
        end
        acq_pkg::ST_HOLD: begin
          // low start pulse kept at least 25 ns before next start
          if (cnt_reg >= CW'(acq_pkg::C_START_HI - 1)) state_reg <= acq_pkg::ST_IDLE;
        end
        default: state_reg <= acq_pkg::ST_IDLE;
      endcase
    end
  end

  // cycle timer, busy watch and sticky status; set wins over clear
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      cyc_reg       <= '0;
      busy_prev_reg <= 1'b0;
      done_reg      <= 1'b0;
      late_reg      <= 1'b0;
      over_reg      <= 1'b0;
      O_READ_OK     <= 1'b0;
    end else begin
      busy_prev_reg <= I_BUSY;
      if (state_reg == acq_pkg::ST_IDLE && start_req_reg) cyc_reg <= '0;
      else cyc_reg <= cyc_reg + CW'(1);
      // select may only be asserted once busy is low
      // low too in the cycle a start is launched, so it never meets a start pulse
      O_READ_OK <= !I_BUSY && !start_go && state_reg != acq_pkg::ST_WAIT &&
                   state_reg != acq_pkg::ST_START;
      if (busy_fall) done_reg <= 1'b1;
      else if (wr_ctrl && I_WB_SEL[0] && I_WB_DAT[acq_pkg::F_START]) done_reg <= 1'b0;
      if (state_reg == acq_pkg::ST_CONV && cyc_reg > conv_lim) late_reg <= 1'b1;
      else if (wr_ctrl && I_WB_SEL[0] && I_WB_DAT[acq_pkg::F_RESET]) late_reg <= 1'b0;
      if (busy_fall && cyc_reg > (ctrl_reg[acq_pkg::F_SERIAL] ? CW'(acq_pkg::C_CYC_SER)
                                                            : CW'(acq_pkg::C_CYC_PAR)))
        over_reg <= 1'b1;
      else if (wr_ctrl && I_WB_SEL[0] && I_WB_DAT[acq_pkg::F_RESET]) over_reg <= 1'b0;
    end
  end

  // pin levels mirrored from control
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_LOW_POWER_REQUEST_B <= 1'b1;
      O_OVERSAMPLE_SELECT   <= 3'h0;
    end else begin
      O_LOW_POWER_REQUEST_B <= !ctrl_reg[acq_pkg::F_LOWP];
      // ratio changes only away from a conversion
      if (state_reg == acq_pkg::ST_IDLE) O_OVERSAMPLE_SELECT <= ctrl_reg[acq_pkg::F_OS +: 3];
    end
  end
endmodule : acq_host
`default_nettype wire

// [design/acq_pkg.sv]
// package for the conversion sequencing host controller
// assumes a 125 MHz system clock; counts derive from times in ns
package acq_pkg;
  // clock period in ns
  localparam int unsigned CLK_NS = 8;
  // timing figures in their own units
  localparam int unsigned T_RESET_NS     = 50;
  localparam int unsigned T_RST_CONV_NS  = 25;
  localparam int unsigned T_LOW_POWER_REQUEST_US      = 100;
  localparam int unsigned T_SHDN_INT_MS  = 30;
  localparam int unsigned T_SHDN_EXT_MS  = 13;
  localparam int unsigned T_AB_SKEW_US   = 500;  // 0.5 ms
  localparam int unsigned T_CYCLE_PAR_NS = 5000;
  localparam int unsigned T_CYCLE_SER_NS = 9100;
  localparam int unsigned T_CONV_OFF_NS  = 4200;
  // cycle counts: reset times round up, wake waits and longest times round down
  localparam int unsigned C_RESET    = (T_RESET_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned C_RST_CONV = (T_RST_CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned C_LOW_POWER_REQUEST     = T_LOW_POWER_REQUEST_US * 1000 / CLK_NS;
  localparam int unsigned C_SHDN_INT = T_SHDN_INT_MS * 1000 * 1000 / CLK_NS;
  localparam int unsigned C_SHDN_EXT = T_SHDN_EXT_MS * 1000 * 1000 / CLK_NS;
  localparam int unsigned C_AB_SKEW  = T_AB_SKEW_US * 1000 / CLK_NS;
  localparam int unsigned C_CYC_PAR  = T_CYCLE_PAR_NS / CLK_NS;
  localparam int unsigned C_CYC_SER  = T_CYCLE_SER_NS / CLK_NS;
  localparam int unsigned C_CONV_OFF = T_CONV_OFF_NS / CLK_NS;
  // start pulse high length, at least 25 ns
  localparam int unsigned C_START_HI = C_RST_CONV;
  // register byte addresses
  localparam logic [3:0] ADR_CTRL   = 4'h0;
  localparam logic [3:0] ADR_STATUS = 4'h4;
  localparam logic [3:0] ADR_SKEW   = 4'h8;
  // control field positions
  localparam int unsigned F_START  = 0;  // write 1: start a conversion
  localparam int unsigned F_RESET  = 1;  // write 1: pulse device reset
  localparam int unsigned F_LOWP   = 2;  // low power request level
  localparam int unsigned F_SHDN   = 3;  // 1: low power is shutdown
  localparam int unsigned F_EXTREF = 4;  // 1: external reference in use
  localparam int unsigned F_SERIAL = 5;  // 1: serial read cycle budget
  localparam int unsigned F_OS     = 8;  // oversample_select, 3 bits
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // status field positions
  localparam int unsigned S_READY   = 0;
  localparam int unsigned S_BUSY    = 1;
  localparam int unsigned S_DONE    = 2;
  localparam int unsigned S_LATE    = 3;  // busy outlasted its limit
  localparam int unsigned S_OVERRUN = 4;  // cycle budget exceeded
  // sequencer states, gray along the usual path except hold back to idle, which flips two bits
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_WAIT  = 3'b011,
    ST_CONV  = 3'b010,
    ST_HOLD  = 3'b110,
    ST_RESET = 3'b100,
    ST_WAKE  = 3'b101
  } acq_state_e;
endpackage : acq_pkg
